//--- verif/pin_partner.sv
/*
 Model of the board wiring seen by the eight port pins.
 Assumes the block's drive, enable and pull-up outputs are registered on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Pin wiring model
module pin_partner (
    input wire logic clk_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pu_i,
    output logic [7:0] level_o
);
    logic [7:0] flt = 8'h55;

    // Undriven lines drift every cycle so a stale value never passes as real
    always @(posedge clk_i) begin
        flt <= ~flt;
    end

    // Wire level: block drive, else weak pull-up, else drifting line
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_o[i] = oe_i[i] ? drv_i[i] : (pu_i[i] ? 1'b1 : flt[i]);
        end
    end
endmodule : pin_partner
`default_nettype wire

//--- verif/test_gpio_port_e_pin_mux.sv
/*
 Self-checking bench for the port E pin multiplexer: driver with queued
 expectations, monitor comparing on read ack or on a snapshot strobe.
 Assumes the one-wait-state Wishbone slave and registered pin outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module test_gpio_port_e_pin_mux;
    import gpio_e_pkg::*;
    logic clk_i;
    logic rst_i = 1'b1;
    logic [21:0] req = '0;
    logic snap = 1'b0;
    logic [7:0] pv = '0, dout = '0, pen = '0, ptri = '0, L, D, P, E, E2;
    logic [4:0] pm = '0;
    logic boe = 1'b0, pmpen = 1'b0, refclk = 1'b0, R;
    logic [31:0] seed = 32'h4109;
    logic [67:0] q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, unit13_on_port_h_o, capture_in_o;
    wire logic [7:0] pin_i, pin_o, pin_oe_o, pullup_o, ext_bus_din_o;
    wire logic [33:0] obs;
    logic [7:0] ra [6] = '{OFS_LATCH, OFS_DIR, OFS_PULLUP_G, OFS_MEMCTL, OFS_CONFIG, 8'h18};
    logic [7:0] rv [6] = '{RST_LATCH, RST_DIR, RST_PULLUP_G, RST_MEMCTL, RST_CONFIG, 8'h00};

    // ============================================================
    // Clock, design and pin wiring
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    assign obs = {unit13_on_port_h_o, capture_in_o, ext_bus_din_o, pin_o & pin_oe_o,
        pin_oe_o, pullup_o};
    gpio_port_e_pin_mux dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req[21]),
        .wb_stb_i(req[21]), .wb_we_i(req[20]), .wb_adr_i(req[19:12]), .wb_sel_i(req[11:8]),
        .wb_dat_i({24'h0, req[7:0]}), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
        .ext_bus_dout_i(dout), .ext_bus_oe_i(boe), .ext_bus_din_o(ext_bus_din_o),
        .unit1_pwm_b_i(pv[6]), .unit1_pwm_c_i(pv[5]), .unit2_pwm_a_i(pv[7]),
        .unit2_pwm_b_i(pv[2]), .unit2_pwm_c_i(pv[1]), .unit2_pwm_d_i(pv[0]),
        .unit3_pwm_b_i(pv[4]), .unit3_pwm_c_i(pv[3]), .pwm_en_i(pen), .pwm_tri_i(ptri),
        .pmp_en_i(pmpen), .pmp_read_strobe_i(pm[0]), .pmp_write_strobe_i(pm[1]),
        .pmp_byte_enable_i(pm[2]), .pmp_addr_bit13_i(pm[3]), .pmp_addr_bit12_i(pm[4]),
        .refclk_i(refclk), .capture_in_o(capture_in_o),
        .unit13_on_port_h_o(unit13_on_port_h_o));
    pin_partner wiring (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o), .pu_i(pullup_o),
        .level_o(pin_i));

    // ============================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic end_sim;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // Classic cycle: hold until ack is sampled, then idle one cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
        input logic [3:0] sel);
        req <= {1'b1, we, adr, sel, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        req <= '0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [7:0] v);
        q.push_back({34'h0_ffff_ffff, 26'h0, v});
        wb(1'b0, adr, 8'h00, 4'hf);
    endtask : rd

    // Let registered outputs settle, then strobe one snapshot
    task automatic look(input logic [33:0] v, input logic [33:0] m);
        q.push_back({m, v & m});
        repeat (3) @(posedge clk_i);
        snap <= 1'b1;
        @(posedge clk_i);
        snap <= 1'b0;
    endtask : look

    task automatic cmp(input logic [33:0] got);
        logic [67:0] e;
        e = q.pop_front();
        total_checks++;
        if ((got & e[67:34]) !== e[33:0]) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e[33:0], got & e[67:34]);
        end
    endtask : cmp

    // ============================================================
    // Monitor and watchdog
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && req[21] && !req[20]) cmp({2'b00, wb_dat_o});
        if (snap) cmp(obs);
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end

    // ============================================================
    // Scenarios, run twice so the second pass starts from a mid-run reset
    initial begin
        for (int it = 0; it < 2; it++) begin
            rst_i <= 1'b1;
            {pv, pm, dout, boe, pen, ptri, pmpen, refclk} <= '0;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            look(34'h0, 34'h3_00ff_ffff);
            for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
            seed = xs(seed);
            L = seed[7:0];
            wb(1'b1, OFS_DIR, 8'h03, 4'h1);
            wb(1'b1, OFS_PIN, L, 4'h1);
            wb(1'b1, OFS_LATCH, ~L, 4'he);
            rd(OFS_LATCH, L);
            wb(1'b1, OFS_PULLUP_G, 8'h40, 4'h1);
            look({2'b00, L[7:2], 2'b11, L & 8'hfc, 8'hfc, 8'h03}, '1);
            rd(OFS_PIN, {L[7:2], 2'b11});
            // External bus owns the pins on the large package
            seed = xs(seed);
            D = seed[7:0];
            {boe, dout} <= {1'b1, D};
            wb(1'b1, OFS_MEMCTL, 8'h00, 4'h1);
            look({2'b00, D, D, 8'hff, 8'h00}, '1);
            boe <= 1'b0;
            look({2'b00, 8'hff, 8'h00, 8'h00, 8'hff}, '1);
            wb(1'b1, OFS_CONFIG, 8'h17, 4'h1);
            boe <= 1'b1;
            look({2'b00, L[7:2], 2'b11, L & 8'hfc, 8'hfc, 8'h03}, '1);
            // PWM outputs beat the latch and the parallel port
            seed = xs(seed);
            {P, pm, R} = {seed[7:0], seed[12:8], seed[13]};
            {pv, pen, pmpen, boe} <= {P, 8'h7f, 1'b1, 1'b0};
            wb(1'b1, OFS_CONFIG, 8'h1f, 4'h1);
            wb(1'b1, OFS_MEMCTL, 8'h80, 4'h1);
            wb(1'b1, OFS_DIR, 8'h00, 4'h1);
            E = {L[7], P[6:0]};
            look({2'b00, E, E, 8'hff, 8'h00}, '1);
            ptri <= 8'h05;
            look({2'b00, (E & 8'hfa) | 8'h05, E & 8'hfa, 8'hfa, 8'h05}, '1);
            ptri <= 8'h00;
            pen <= 8'hff;
            wb(1'b1, OFS_CONFIG, 8'h1c, 4'h1);
            E2 = {P[7], L[6:5], pm[4:3], P[2:0]};
            look({1'b1, P[7], E2, E2, 8'hff, 8'h00}, '1);
            // Parallel port strobes and address, reference clock on pin three
            {pen, refclk} <= {8'h00, R};
            wb(1'b1, OFS_DIR, 8'hff, 4'h1);
            wb(1'b1, OFS_CONFIG, 8'h3b, 4'h1);
            look({2'b00, 3'b111, pm[4], R, pm[2:0], 3'b000, pm[4], R, pm[2:0], 8'h1f, 8'he0},
                '1);
        end
        end_sim();
    end
endmodule : test_gpio_port_e_pin_mux
`default_nettype wire

//--- verilog/gpio_e_pkg.sv
/*
 Constants shared by the port E pin multiplexer: register offsets, field
 positions, reset values and pin assignments of the alternate functions.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
// ============================================================
// Package
package gpio_e_pkg;
    localparam int DATA_W = 32;
    localparam int ADR_W = 8;
    localparam int PORT_W = 8;
    localparam int CLK_PERIOD_NS = 50;

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFS_PIN = 8'h00;
    localparam logic [7:0] OFS_LATCH = 8'h04;
    localparam logic [7:0] OFS_DIR = 8'h08;
    localparam logic [7:0] OFS_PULLUP_G = 8'h0c;
    localparam logic [7:0] OFS_MEMCTL = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;

    // ============================================================
    // Field positions
    localparam int BIT_SHARED_PULLUP = 6;
    localparam int BIT_EXT_BUS_DISABLE = 7;
    localparam int CFG_PWM_REMAP = 0;
    localparam int CFG_UNIT2_REMAP = 1;
    localparam int CFG_PMP_REMAP = 2;
    localparam int CFG_LARGE_PKG = 3;
    localparam int CFG_MCU_MODE = 4;
    localparam int CFG_REFERENCE_CLOCK_OUT_EN = 5;

    // ============================================================
    // Reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_PULLUP_G = 8'h00;
    localparam logic [7:0] RST_MEMCTL = 8'h80;
    localparam logic [7:0] RST_CONFIG = 8'h1f;

    // ============================================================
    // Pin positions of single alternate functions
    localparam int PIN_PMP_RD = 0;
    localparam int PIN_PMP_WR = 1;
    localparam int PIN_REFERENCE_CLOCK_OUT = 3;
    localparam int PIN_UNIT2_A = 7;

    // Source that owns a pin
    typedef enum {SRC_LATCH, SRC_BUS, SRC_PWM, SRC_REFERENCE_CLOCK_OUT, SRC_PMP} pin_src_t;

    // Word decode of a byte address
    function automatic logic word_hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr[7:2] == ofs[7:2];
    endfunction : word_hit
endpackage : gpio_e_pkg

//--- verilog/gpio_port_e_pin_mux.sv
/*
 Eight-bit port with direction, output latch, shared pull-up enable and
 alternate functions: external bus high byte, PWM outputs, parallel master
 port strobes and address, reference clock. Registers over classic Wishbone.
 Assumes all pin and peripheral inputs are synchronous to clk_i.
*/
// The address map and the Wishbone interface to the registers were chosen for this implementation.
// How it works
// R1: Eight pins, each input or output by its own direction bit.
// R2: Every reset turns all eight pins into inputs.
// R3: On the large package port functions need the external bus disabled.
// R4: Enabled external bus owns the pins; direction bits are ignored.
// R5: Bus drives pins with address/data high byte regardless of direction.
// R6: Each pin has a pull-up; clearing the shared bit disables all.
// R7: A pin driven as output never has its pull-up on.
// R8: Reset leaves every pull-up off.
// R9: PWM outputs of the three units sit on pins six to zero by default.
// R10: Large package with remap bit clear moves units one and three away.
// R11: Microcontroller mode, unit two remap clear, puts its signal on pin seven.
// R12: Parallel remap bit clear puts write and read strobes on pins one, zero.
// R13: Pins two to four carry byte enable and address bits thirteen, twelve.
// R14: PWM channels appear on their pins when the direction bit is zero.
// R15: Enabled PWM beats latch and parallel port; may tri-state on shutdown.
// R16: Pin three may output the reference clock regardless of direction.
// R17: Direction one means input, zero means output.
// R18: External bus use beats every other function of the pin.
// R19: Pin or latch writes set the latch; pin read gives levels.
// R20: Priority is bus, PWM, parallel port, then latch under direction.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Top
module gpio_port_e_pin_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gpio_e_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [gpio_e_pkg::DATA_W-1:0] wb_dat_i,
    output logic [gpio_e_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic [gpio_e_pkg::PORT_W-1:0] pin_i,
    output logic [gpio_e_pkg::PORT_W-1:0] pin_o,
    output logic [gpio_e_pkg::PORT_W-1:0] pin_oe_o,
    output logic [gpio_e_pkg::PORT_W-1:0] pullup_o,
    // External bus
    input wire logic [7:0] ext_bus_dout_i,
    input wire logic ext_bus_oe_i,
    output logic [7:0] ext_bus_din_o,
    // PWM values
    input wire logic unit1_pwm_b_i,
    input wire logic unit1_pwm_c_i,
    input wire logic unit2_pwm_a_i,
    input wire logic unit2_pwm_b_i,
    input wire logic unit2_pwm_c_i,
    input wire logic unit2_pwm_d_i,
    input wire logic unit3_pwm_b_i,
    input wire logic unit3_pwm_c_i,
    input wire logic [7:0] pwm_en_i,
    input wire logic [7:0] pwm_tri_i,
    // Parallel port
    input wire logic pmp_en_i,
    input wire logic pmp_read_strobe_i,
    input wire logic pmp_write_strobe_i,
    input wire logic pmp_byte_enable_i,
    input wire logic pmp_addr_bit13_i,
    input wire logic pmp_addr_bit12_i,
    // Clock and flags
    input wire logic refclk_i,
    output logic capture_in_o,
    output logic unit13_on_port_h_o
);
    import gpio_e_pkg::*;

    // ============================================================
    // Registers and bus strobes
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pullup_g;
    logic [7:0] memctl;
    logic [7:0] config_bits;
    logic [7:0] next_rdata;
    logic wr;
    logic rd;
    logic unit2a_here;
    logic [7:0] pwm_val;
    logic [7:0] pmp_val;

    pin_ctrl_if ctrl ();

    // Bus handshake with one wait state
    wb_slave_port u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .sel0_i(wb_sel_i[0]),
        .ack_o(wb_ack_o),
        .wr_o(wr),
        .rd_o(rd)
    );

    // Output latch, written through either the pin or the latch address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch <= RST_LATCH;
        end else if (wr && (word_hit(wb_adr_i, OFS_PIN) || word_hit(wb_adr_i, OFS_LATCH))) begin
            latch <= wb_dat_i[7:0]; // R19
        end
    end

    // Direction register, all inputs after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir <= RST_DIR; // R2
        end else if (wr && word_hit(wb_adr_i, OFS_DIR)) begin
            dir <= wb_dat_i[7:0]; // R17
        end
    end

    // Pull-up enables and neighbour port bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_g <= RST_PULLUP_G; // R8
        end else if (wr && word_hit(wb_adr_i, OFS_PULLUP_G)) begin
            pullup_g <= wb_dat_i[7:0];
        end
    end

    // Memory control, holding the external bus disable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            memctl <= RST_MEMCTL;
        end else if (wr && word_hit(wb_adr_i, OFS_MEMCTL)) begin
            memctl <= wb_dat_i[7:0]; // R3
        end
    end

    // Remap and package configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_bits <= RST_CONFIG;
        end else if (wr && word_hit(wb_adr_i, OFS_CONFIG)) begin
            config_bits <= wb_dat_i[7:0];
        end
    end

    // Read selection; unmapped words read zero
    always_comb begin
        next_rdata = 8'h00;
        if (word_hit(wb_adr_i, OFS_PIN)) begin
            next_rdata = ctrl.pin_level; // R19
        end else if (word_hit(wb_adr_i, OFS_LATCH)) begin
            next_rdata = latch;
        end else if (word_hit(wb_adr_i, OFS_DIR)) begin
            next_rdata = dir;
        end else if (word_hit(wb_adr_i, OFS_PULLUP_G)) begin
            next_rdata = pullup_g;
        end else if (word_hit(wb_adr_i, OFS_MEMCTL)) begin
            next_rdata = memctl;
        end else if (word_hit(wb_adr_i, OFS_CONFIG)) begin
            next_rdata = config_bits;
        end
    end

    // Read data register, loaded the cycle before ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd) begin
            wb_dat_o <= {24'h000000, next_rdata};
        end
    end

    // ============================================================
    // Control bundle to the multiplexer
    assign ctrl.latch = latch;
    assign ctrl.dir = dir;
    assign ctrl.shared_pullup = pullup_g[BIT_SHARED_PULLUP]; // R6
    assign ctrl.large_pkg = config_bits[CFG_LARGE_PKG];
    assign ctrl.bus_active = config_bits[CFG_LARGE_PKG] & ~memctl[BIT_EXT_BUS_DISABLE]; // R3
    assign ctrl.pwm_remap = config_bits[CFG_PWM_REMAP];
    assign ctrl.unit2_remap = config_bits[CFG_UNIT2_REMAP];
    assign ctrl.pmp_remap = config_bits[CFG_PMP_REMAP];
    assign ctrl.mcu_mode = config_bits[CFG_MCU_MODE];
    assign ctrl.reference_clock_out_en = config_bits[CFG_REFERENCE_CLOCK_OUT_EN];

    // Peripheral signals ordered by pin
    assign pwm_val = {unit2_pwm_a_i, unit1_pwm_b_i, unit1_pwm_c_i, unit3_pwm_b_i,
        unit3_pwm_c_i, unit2_pwm_b_i, unit2_pwm_c_i, unit2_pwm_d_i}; // R9
    assign pmp_val = {3'b000, pmp_addr_bit12_i, pmp_addr_bit13_i, pmp_byte_enable_i,
        pmp_write_strobe_i, pmp_read_strobe_i};

    // Pin owner selection and drive
    pin_mux u_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl(ctrl),
        .pin_i(pin_i),
        .ext_bus_dout_i(ext_bus_dout_i),
        .ext_bus_oe_i(ext_bus_oe_i),
        .pwm_val_i(pwm_val),
        .pwm_en_i(pwm_en_i),
        .pwm_tri_i(pwm_tri_i),
        .pmp_en_i(pmp_en_i),
        .pmp_val_i(pmp_val),
        .refclk_i(refclk_i),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o),
        .pullup_o(pullup_o),
        .unit13_on_port_h_o(unit13_on_port_h_o),
        .unit2a_here_o(unit2a_here)
    );

    // Read data toward the bus and the capture input
    assign ext_bus_din_o = ctrl.pin_level; // R5
    assign capture_in_o = unit2a_here & ctrl.pin_level[PIN_UNIT2_A]; // R11

    // ============================================================
    // Assertions
    logic quiet;
    assign quiet = ~ctrl.bus_active & (pwm_en_i == 8'h00) & ~pmp_en_i & ~ctrl.reference_clock_out_en;

    sequence s_write_taken(logic [7:0] ofs);
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && word_hit(wb_adr_i, ofs);
    endsequence

    sequence s_read_taken(logic [7:0] ofs);
        wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o && word_hit(wb_adr_i, ofs);
    endsequence

    a_reset_inputs: assert property (@(posedge clk_i) rst_i |=> pin_oe_o == 8'h00) // R2
        else $error("pins driven after reset");

    a_reset_pullups: assert property (@(posedge clk_i) rst_i |=> pullup_o == 8'h00) // R8
        else $error("pull-ups on after reset");

    a_pullup_driven: assert property (@(posedge clk_i) disable iff (rst_i)
        (pullup_o & pin_oe_o) == 8'h00) // R7
        else $error("pull-up on a driven pin");

    a_shared_pullup_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.shared_pullup |=> pullup_o == 8'h00) // R6
        else $error("pull-up on with shared enable clear");

    a_bus_owns_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl.bus_active |=> pin_oe_o == {8{$past(ext_bus_oe_i)}}
        && (!$past(ext_bus_oe_i) || pin_o == $past(ext_bus_dout_i))) // R4
        else $error("external bus lost a pin");

    a_dir_controls: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet |=> pin_oe_o == ~$past(dir) && pin_o == $past(latch)) // R17
        else $error("direction or latch not on pins");

    a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_write_taken(OFS_PIN) or s_write_taken(OFS_LATCH)) |=> latch == $past(wb_dat_i[7:0]))
        // R19
        else $error("latch write lost");

    a_pin_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_taken(OFS_PIN) |-> wb_dat_o == {24'h000000, $past(ctrl.pin_level)}) // R19
        else $error("pin read returns wrong level");

    a_ack_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) // R19
        else $error("ack timing wrong");

    a_reference_clock_out_pin3: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.bus_active && ctrl.reference_clock_out_en && !(pwm_en_i[PIN_REFERENCE_CLOCK_OUT] && !dir[PIN_REFERENCE_CLOCK_OUT])
        |=> pin_oe_o[PIN_REFERENCE_CLOCK_OUT] && pin_o[PIN_REFERENCE_CLOCK_OUT] == $past(refclk_i)) // R16
        else $error("reference clock missing on pin 3");

    a_pmp_strobes: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.bus_active && pmp_en_i && !ctrl.pmp_remap && (pwm_en_i[1:0] == 2'b00)
        |=> pin_oe_o[1:0] == 2'b11
        && pin_o[1:0] == {$past(pmp_write_strobe_i), $past(pmp_read_strobe_i)}) // R12
        else $error("parallel strobes not on pins 1 and 0");

    a_pwm_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.bus_active && pwm_en_i[0] && !dir[0] && pwm_tri_i[0] |=> !pin_oe_o[0]) // R15
        else $error("PWM shutdown did not release pin 0");

    a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_taken(OFS_DIR) |=> dir == $past(wb_dat_i[7:0])) // R17
        else $error("direction write lost");

    a_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) // R19
        else $error("read data upper bits set");

    a_units_to_port_h: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl.large_pkg && !ctrl.pwm_remap |=> unit13_on_port_h_o) // R10
        else $error("units one and three not moved");

    a_unit2_on_pin7: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl.bus_active && ctrl.mcu_mode && !ctrl.unit2_remap
        && pwm_en_i[PIN_UNIT2_A] && !dir[PIN_UNIT2_A] && !pwm_tri_i[PIN_UNIT2_A]
        |=> pin_oe_o[PIN_UNIT2_A] && pin_o[PIN_UNIT2_A] == $past(unit2_pwm_a_i)) // R11
        else $error("unit two output missing on pin 7");
endmodule : gpio_port_e_pin_mux
`default_nettype wire

//--- verilog/pin_ctrl_if.sv
/*
 Control bundle from the register file to the pin multiplexer, and the
 sampled pin levels back. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Interface
interface pin_ctrl_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic shared_pullup;
    logic bus_active;
    logic pwm_remap;
    logic unit2_remap;
    logic pmp_remap;
    logic large_pkg;
    logic mcu_mode;
    logic reference_clock_out_en;
    logic [7:0] pin_level;

    modport regs (output latch, dir, shared_pullup, bus_active, pwm_remap, unit2_remap,
        pmp_remap, large_pkg, mcu_mode, reference_clock_out_en, input pin_level);
    modport mux (input latch, dir, shared_pullup, bus_active, pwm_remap, unit2_remap,
        pmp_remap, large_pkg, mcu_mode, reference_clock_out_en, output pin_level);
endinterface : pin_ctrl_if
`default_nettype wire

//--- verilog/pin_mux.sv
/*
 Per-pin owner selection, output and enable registers, pull-up control and
 pin sampling. Assumes pins and peripheral signals are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Pin multiplexer
module pin_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    pin_ctrl_if.mux ctrl,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] ext_bus_dout_i,
    input wire logic ext_bus_oe_i,
    input wire logic [7:0] pwm_val_i,
    input wire logic [7:0] pwm_en_i,
    input wire logic [7:0] pwm_tri_i,
    input wire logic pmp_en_i,
    input wire logic [7:0] pmp_val_i,
    input wire logic refclk_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] pullup_o,
    output logic unit13_on_port_h_o,
    output logic unit2a_here_o
);
    import gpio_e_pkg::*;

    pin_src_t src [8];
    logic [7:0] pwm_here;
    logic [7:0] pmp_here;
    logic [7:0] next_out;
    logic [7:0] next_oe;
    logic unit13_here;
    logic unit2a_here;

    // Site of each PWM output and PMP signal
    always_comb begin
        unit13_here = ~(ctrl.large_pkg & ~ctrl.pwm_remap); // R10
        unit2a_here = ctrl.mcu_mode & ~ctrl.unit2_remap; // R11
        pwm_here = {unit2a_here, {2{unit13_here}}, {2{unit13_here}}, 3'b111}; // R9 R14
        pmp_here = {8{pmp_en_i}} & {3'b000, 3'b111, {2{~ctrl.pmp_remap}}}; // R12 R13
    end

    // Owner of each pin: bus, PWM, reference clock, PMP, then latch
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            src[i] = SRC_LATCH;
            if (ctrl.bus_active) begin // R4 R18 R20
                src[i] = SRC_BUS;
            end else if (pwm_here[i] && pwm_en_i[i] && !ctrl.dir[i]) begin // R14 R15
                src[i] = SRC_PWM;
            end else if (i == PIN_REFERENCE_CLOCK_OUT && ctrl.reference_clock_out_en) begin // R16
                src[i] = SRC_REFERENCE_CLOCK_OUT;
            end else if (pmp_here[i]) begin // R13
                src[i] = SRC_PMP;
            end
        end
    end

    // Value and drive for each owner
    always_comb begin
        next_out = 8'h00;
        next_oe = 8'h00;
        for (int i = 0; i < PORT_W; i++) begin
            case (src[i])
                SRC_BUS: begin
                    next_out[i] = ext_bus_dout_i[i]; // R5
                    next_oe[i] = ext_bus_oe_i;
                end
                SRC_PWM: begin
                    next_out[i] = pwm_val_i[i];
                    next_oe[i] = ~pwm_tri_i[i]; // R15
                end
                SRC_REFERENCE_CLOCK_OUT: begin
                    next_out[i] = refclk_i;
                    next_oe[i] = 1'b1;
                end
                SRC_PMP: begin
                    next_out[i] = pmp_val_i[i];
                    next_oe[i] = 1'b1;
                end
                default: begin
                    next_out[i] = ctrl.latch[i];
                    next_oe[i] = ~ctrl.dir[i]; // R1 R17
                end
            endcase
        end
    end

    // Pin drive registers; every pin an input from reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 8'h00;
            pin_oe_o <= 8'h00; // R2
        end else begin
            pin_o <= next_out;
            pin_oe_o <= next_oe;
        end
    end

    // Pull-ups: shared enable, dropped on any driven pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_o <= 8'h00; // R8
        end else begin
            pullup_o <= {8{ctrl.shared_pullup}} & ~next_oe; // R6 R7
        end
    end

    // Pin sampling and site flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl.pin_level <= 8'h00;
            unit13_on_port_h_o <= 1'b0;
            unit2a_here_o <= 1'b0;
        end else begin
            ctrl.pin_level <= pin_i;
            unit13_on_port_h_o <= ~unit13_here;
            unit2a_here_o <= unit2a_here;
        end
    end
endmodule : pin_mux
`default_nettype wire

//--- verilog/wb_slave_port.sv
/*
 Classic Wishbone handshake: one wait state, ack one cycle after the request.
 Assumes the master holds the request until it samples ack.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bus handshake
module wb_slave_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic sel0_i,
    output logic ack_o,
    output logic wr_o,
    output logic rd_o
);
    logic ack;

    // Ack rises one cycle after the request and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= cyc_i & stb_i & ~ack;
        end
    end

    // Read data is captured before ack; a write lands on the acking edge
    assign ack_o = ack;
    assign rd_o = cyc_i & stb_i & ~ack;
    assign wr_o = cyc_i & stb_i & we_i & sel0_i & ack;
endmodule : wb_slave_port
`default_nettype wire
